// ### haptic_closed_loop_control_test.sv
// Purpose: Self-checking bench for the haptic controller.
// Assumes: Bench is the two-wire master; model is the actuator.
// Notes: Millisecond count shortened so calibration is brief.
`default_nettype none

module haptic_closed_loop_control_test import hcl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 32;
  localparam logic [6:0] DEV = 7'h2c;
  logic clk, rst_n, scl, m_sda, sda_in, sda_out, sda_oe_n;
  logic zc, out_pos, out_neg;
  logic [7:0] bemf, imp, level, imp_set;
  logic [15:0] half_cyc;
  int n_mismatch, checks;

  assign sda_in = m_sda && (sda_oe_n || sda_out);

  hcl_top #(.DEV_ADDR(DEV), .MS_CYC(16)) dut_u (
    .CLOCK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .BEMF_ZC(zc),
    .BEMF_LEVEL(bemf), .LOAD_IMPEDANCE(imp),
    .OUT_POS(out_pos), .OUT_NEG(out_neg));

  hcl_actuator_model act_u (
    .clk(clk), .out_pos(out_pos), .out_neg(out_neg),
    .half_cyc(half_cyc), .level(level), .imp(imp_set),
    .zc(zc), .bemf(bemf), .load_imp(imp));

  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bit_io(input logic b, output logic r);
    tick(4);
    m_sda <= b;
    tick(H - 4);
    scl <= 1'b1;
    tick(H / 2);
    r = sda_in;
    tick(H / 2);
    scl <= 1'b0;
  endtask

  task automatic i2c_start;
    tick(4);
    m_sda <= 1'b1;
    tick(H - 4);
    scl <= 1'b1;
    tick(H);
    m_sda <= 1'b0;
    tick(H);
    scl <= 1'b0;
  endtask

  task automatic i2c_stop;
    tick(4);
    m_sda <= 1'b0;
    tick(H - 4);
    scl <= 1'b1;
    tick(H);
    m_sda <= 1'b1;
    tick(H);
  endtask

  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, a);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k0, k1, k2;
    i2c_start();
    xfer({DEV, 1'b0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    i2c_stop();
    chk("write ack", 8'h00, {5'h00, k0, k1, k2});
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k0, k1, k2, k3;
    i2c_start();
    xfer({DEV, 1'b0}, q, k0);
    xfer(a, q, k1);
    i2c_start();
    xfer({DEV, 1'b1}, q, k2);
    xfer(8'hff, q, k3);
    i2c_stop();
    chk("read ack", 8'h00, {5'h00, k0, k1, k2});
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(nm, e, q);
  endtask

  task automatic wait_cal;
    logic [7:0] q;
    int k;
    for (k = 0; k < 8; k++) begin
      rd(A_STATUS, q);
      if (q[ST_CAL] === 1'b0)
        break;
    end
    if (k == 8) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    rc("run", A_RUN, RUN_RST);
    rc("fbctl", A_FBCTL, FBCTL_RST);
    rc("loop3", A_LOOP3, LOOP3_RST);
    wr(A_STATUS, 8'hff);
    rc("status", A_STATUS, 8'h00);
    rc("unmapped", 8'h7e, 8'h00);
  endtask

  task automatic t_fields;
    wr(A_FBCTL, 8'hfc);
    rc("fbctl", A_FBCTL, 8'hfc);
    wr(A_LOOP3, 8'h31);
    rc("loop3", A_LOOP3, 8'h31);
  endtask

  task automatic t_cal;
    logic [7:0] q;
    wr(A_RUN, 8'h1e);
    rd(A_STATUS, q);
    chk("cal busy", 8'h01, {7'h00, q[ST_CAL]});
    wait_cal();
    rc("comp", A_COMP, 8'h40);
    rc("norm", A_NORM, 8'((32'(RATED_RST) * 128) / 64));
    rc("status", A_STATUS, 8'h00);
    imp_set <= 8'hff;
    wr(A_RUN, 8'h0e);
    wait_cal();
    rc("status", A_STATUS, 8'h01 << ST_FAULT);
  endtask

  task automatic t_lra;
    logic [7:0] q;
    logic pol;
    int n;
    wr(A_LOOP3, 8'h30);
    wr(A_TIMING, 8'h22);
    wr(A_AMPL, 8'hff);
    wr(A_RUN, 8'h0d);
    n = 0;
    pol = out_pos;
    repeat (5500) begin
      @(posedge clk);
      if ((out_pos && !pol) || (out_neg && pol)) begin
        n++;
        pol = out_pos;
      end
    end
    chk("open loop flips", 8'h01, {7'h00, n >= 2});
    rc("status", A_STATUS, 8'h09);
    half_cyc <= 16'd6155;
    tick(13000);
    rc("status", A_STATUS, 8'h0d);
    tick(8000);
    rd(A_PERIOD, q);
    chk("period", 8'h01, {7'h00, q >= 8'h04 && q <= 8'h06});
    wr(A_RUN, 8'h0c);
  endtask

  task automatic t_auto;
    half_cyc <= 16'h0000;
    wr(A_LOOP3, 8'h01);
    wr(A_RUN, 8'h0d);
    tick(4000);
    rc("auto", A_STATUS, 8'h19);
  endtask

  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_n = 1'b0;
    scl = 1'b1;
    m_sda = 1'b1;
    half_cyc = 16'h0000;
    level = 8'h40;
    imp_set = 8'h40;
    tick(12);
    rst_n <= 1'b1;
    tick(4);
    t_defaults();
    t_fields();
    t_cal();
    t_lra();
    t_auto();
    finish_test();
  end
endmodule // haptic_closed_loop_control_test

`default_nettype wire

// ### hcl_actuator_model.sv
// Purpose: Behavioural resonant actuator with back-EMF sense.
// Assumes: Crossings only once the bridge has moved the mass.
// Notes: A half period of zero means no valid back-EMF.
`default_nettype none

module hcl_actuator_model (
  // Clock and bridge legs
  input wire logic clk,
  input wire logic out_pos,
  input wire logic out_neg,
  // Bench controls
  input wire logic [15:0] half_cyc,
  input wire logic [7:0] level,
  input wire logic [7:0] imp,
  // Sense outputs
  output logic zc,
  output logic [7:0] bemf,
  output logic [7:0] load_imp
);
  logic [15:0] cnt;
  logic moving;

  assign bemf = level;
  assign load_imp = imp;

  initial begin
    zc = 1'b0;
    cnt = 16'h0000;
    moving = 1'b0;
  end

  always @(posedge clk) begin
    if (out_pos || out_neg)
      moving <= 1'b1;
    if (half_cyc == 16'h0000 || !moving)
      cnt <= 16'h0000;
    else if (cnt >= half_cyc - 16'h0001) begin
      cnt <= 16'h0000;
      zc <= !zc;
    end else
      cnt <= cnt + 16'h0001;
  end
endmodule // hcl_actuator_model

`default_nettype wire

// ### hcl_eng_if.sv
// Purpose: Link between controller and resonance engine.
// Assumes: Both ends on one clock.
// Notes: Controller drives configuration, engine reports timing.
`default_nettype none

interface hcl_eng_if;
  logic lra;
  logic go;
  logic zc;
  logic auto_en;
  logic [1:0] unsync_limit;
  logic [7:0] dflt_half;
  logic [6:0] ol_period;
  logic commut;
  logic locked;
  logic auto_open;
  logic phase;
  logic [7:0] period;
  modport ctl(output lra, go, zc, auto_en, unsync_limit, dflt_half,
    ol_period, input commut, locked, auto_open, phase, period);
  modport eng(input lra, go, zc, auto_en, unsync_limit, dflt_half,
    ol_period, output commut, locked, auto_open, phase, period);
endinterface

`default_nettype wire

// ### hcl_pkg.sv
// Purpose: Shared constants for the haptic closed-loop controller.
// Assumes: 25 MHz system clock.
// Notes: Register offsets, field positions, reset values, timing.
`default_nettype none

package hcl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_RUN = 8'h01;
  localparam logic [7:0] A_AMPL = 8'h02;
  localparam logic [7:0] A_RATED = 8'h16;
  localparam logic [7:0] A_CLAMP = 8'h17;
  localparam logic [7:0] A_COMP = 8'h18;
  localparam logic [7:0] A_NORM = 8'h19;
  localparam logic [7:0] A_FBCTL = 8'h1a;
  localparam logic [7:0] A_TIMING = 8'h1b;
  localparam logic [7:0] A_LOOP3 = 8'h1f;
  localparam logic [7:0] A_OLPER = 8'h20;
  localparam logic [7:0] A_PERIOD = 8'h22;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_ACTIVE = 0;
  localparam int ST_CAL = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_AUTO = 4;
  localparam int RUN_GO = 0;
  localparam int RUN_CAL = 1;
  localparam int RUN_BOOST = 2;
  localparam int RUN_STAB = 3;
  localparam int RUN_CALT = 4;
  localparam int FB_TYPE = 7;
  localparam int FB_RATIO = 4;
  localparam int FB_GAIN = 2;
  localparam int TM_ZCW = 5;
  localparam int L3_AUTO = 0;
  localparam int L3_CNT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RUN_RST = 8'h0c;
  localparam logic [7:0] RATED_RST = 8'h3e;
  localparam logic [7:0] CLAMP_RST = 8'h8c;
  localparam logic [7:0] COMP_RST = 8'h00;
  localparam logic [7:0] NORM_RST = 8'h80;
  localparam logic [7:0] FBCTL_RST = 8'h24;
  localparam logic [7:0] TIMING_RST = 8'h34;
  localparam logic [7:0] LOOP3_RST = 8'h20;
  localparam logic [7:0] OLPER_RST = 8'h33;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TICK_US_X100 = 9849;
  localparam int TICK_CYC = (TICK_US_X100 * 10) / CLK_NS;
  localparam int LRA_MIN_HZ = 125;
  localparam int TO_TICKS = 100000000 / (2 * LRA_MIN_HZ * TICK_US_X100);
  localparam int MS_CYC_DFLT = 1000000 / CLK_NS;
  localparam logic [9:0] CAL_MS0 = 10'd150;
  localparam logic [9:0] CAL_MS1 = 10'd250;
  localparam logic [9:0] CAL_MS2 = 10'd500;
  localparam logic [9:0] CAL_MS3 = 10'd1000;
  localparam logic [4:0] BOOST_MS = 5'd20;

  // ----------------------------------------------------------------
  // Loop thresholds
  // ----------------------------------------------------------------
  localparam logic [7:0] BRAKE_DONE = 8'h08;
  localparam logic [7:0] BRAKE_NEAR = 8'h20;
  localparam logic [7:0] CAL_BEMF_MIN = 8'h10;
  localparam logic [7:0] IMP_OPEN = 8'hff;
  localparam logic [7:0] IMP_SHORT = 8'h00;

endpackage

`default_nettype wire

// ### hcl_res_engine.sv
// Purpose: Resonance tracking, period report and open-loop fallback.
// Assumes: zc is a one-cycle pulse per back-EMF zero crossing.
// Notes: Time is counted in ticks of the fallback period unit.
`default_nettype none

module hcl_res_engine import hcl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller link
  hcl_eng_if.eng e
);

  logic [11:0] presc;
  logic [7:0] tcount;
  logic [7:0] half_prev;
  logic [2:0] misses;
  logic seen;

  wire tick = presc == 12'(TICK_CYC - 1);
  wire enable = e.go && e.lra;
  wire [7:0] tnext = tcount + 8'h01;
  wire [7:0] ol_lo = 8'(e.ol_period >> 1);
  wire [7:0] ol_half = e.phase ? 8'(e.ol_period) - ol_lo : ol_lo;
  wire [8:0] full = {1'b0, half_prev} + {1'b0, tcount};
  wire timeout = e.locked && tnext >= 8'(TO_TICKS);
  wire dflt_due = !e.locked && tnext >= e.dflt_half;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc <= 12'h000;
    end else begin
      presc <= tick ? 12'h000 : presc + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      tcount <= 8'h00;
      half_prev <= 8'h00;
      misses <= 3'h0;
      seen <= 1'b0;
      e.commut <= 1'b0;
      e.locked <= 1'b0;
      e.auto_open <= 1'b0;
      e.phase <= 1'b0;
      if (!rst_n) begin
        e.period <= 8'h00;
      end
    end else begin
      e.commut <= 1'b0;
      if (e.auto_open) begin
        if (tick) begin
          if (tnext >= ol_half) begin
            e.commut <= 1'b1;
            e.phase <= ~e.phase;
            tcount <= 8'h00;
          end else begin
            tcount <= tnext;
          end
        end
      end else if (e.zc) begin
        e.commut <= 1'b1;
        e.phase <= ~e.phase;
        seen <= 1'b1;
        e.locked <= seen;
        if (e.locked) begin
          e.period <= full[8] ? 8'hff : full[7:0];
        end
        half_prev <= tcount;
        tcount <= 8'h00;
        misses <= 3'h0;
      end else if (tick) begin
        if (timeout || dflt_due) begin
          e.commut <= 1'b1;
          e.phase <= ~e.phase;
          e.locked <= 1'b0;
          tcount <= 8'h00;
          if (e.auto_en && e.phase) begin
            if (misses == {1'b0, e.unsync_limit}) begin
              e.auto_open <= 1'b1;
            end else begin
              misses <= misses + 3'h1;
            end
          end
        end else begin
          tcount <= tnext;
        end
      end
    end
  end

endmodule // hcl_res_engine

`default_nettype wire

// ### hcl_top.sv
// Purpose: Haptic closed-loop actuator controller with serial registers.
// Assumes: Two-wire register port; sense inputs come from analog blocks.
// Notes: Drives a three-level pulse-width modulated output bridge.
// Operation
// - Register bit picks rotating-mass or resonant actuator.
// - Lock within half cycle, track each cycle.
// - Tracking needs no calibration, independent of it.
// - Invalid back-EMF: open-loop overdrive at default frequency.
// - Valid back-EMF returns: resume closed-loop tracking.
// - Bit enables automatic open loop without resync.
// - Two-bit count of tolerated unsynchronized cycles.
// - Fallback period field sets frequency; no overdrive/brake.
// - Startup boost raises loop gain during transient.
// - Three-bit ratio sets braking versus driving gain.
// - Brake stabilizer lowers gain near brake end.
// - Full scale gives rated level; clamp limits.
// - Calibration failure sets fault flag in status.
// - Calibration stores resistive-loss compensation factor.
// - Calibration stores back-EMF normalization factor.
// - Two-bit field selects calibration duration.
// - Two-bit loop gain sets settling speed.
// - Output stage is three-level modulated, not linear.
`default_nettype none

module hcl_top import hcl_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h2c,
  parameter int MS_CYC = MS_CYC_DFLT
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Actuator sense
  input wire logic BEMF_ZC,
  input wire logic [7:0] BEMF_LEVEL,
  input wire logic [7:0] LOAD_IMPEDANCE,
  // Output stage
  output logic OUT_POS,
  output logic OUT_NEG
);

  typedef enum logic [8:0] {
    I_IDLE = 9'h001, I_ADDR = 9'h002, I_ACKA = 9'h004,
    I_PTR = 9'h008, I_ACKP = 9'h010, I_WDAT = 9'h020,
    I_ACKW = 9'h040, I_RDAT = 9'h080, I_RACK = 9'h100
  } hcl_i2c_t;

  typedef enum logic [1:0] {C_IDLE = 2'b01, C_RUN = 2'b10} hcl_cal_t;

  localparam int MSW = $clog2(MS_CYC);

  hcl_eng_if eng ();

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic zc_s1, zc_s2, zc_s3;
  logic [7:0] bemf_s1, bemf_s2, imp_s1, imp_s2;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {zc_s1, zc_s2, zc_s3} <= 3'h0;
      bemf_s1 <= 8'h00;
      bemf_s2 <= 8'h00;
      imp_s1 <= 8'h00;
      imp_s2 <= 8'h00;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {SCL, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {SDA_IN, sda_s1, sda_s2};
      {zc_s1, zc_s2, zc_s3} <= {BEMF_ZC, zc_s1, zc_s2};
      bemf_s1 <= BEMF_LEVEL;
      bemf_s2 <= bemf_s1;
      imp_s1 <= LOAD_IMPEDANCE;
      imp_s2 <= imp_s1;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] run_ctl, amp, rated, clamp, comp, norm;
  logic [7:0] fbctl, timing, loop3, olper;
  logic fault_flag;
  hcl_cal_t cst;
  logic [9:0] cal_ms;

  wire cal_busy = cst == C_RUN;
  wire actuator_type_sel = fbctl[FB_TYPE];
  wire [2:0] stop_gain_ratio = fbctl[FB_RATIO +: 3];
  wire [1:0] loop_gain = fbctl[FB_GAIN +: 2];
  wire [1:0] zero_cross_window = timing[TM_ZCW +: 2];
  wire [4:0] drive_time = timing[4:0];
  wire auto_fallback_enable = loop3[L3_AUTO];
  wire [1:0] unsync_cycle_limit = loop3[L3_CNT +: 2];
  wire [6:0] fallback_period = olper[6:0];
  wire [1:0] cal_time = run_ctl[RUN_CALT +: 2];

  function automatic logic [7:0] sat8(input logic signed [13:0] v,
                                      input logic [7:0] lim);
    if (v < 14'sd0) begin
      sat8 = 8'h00;
    end else if (v > $signed({6'h00, lim})) begin
      sat8 = lim;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    unique case (a)
      A_STATUS: rd_mux = {3'h0, eng.auto_open, fault_flag, eng.locked,
                          cal_busy, run_ctl[RUN_GO]};
      A_RUN: rd_mux = {run_ctl[7:2], cal_busy, run_ctl[RUN_GO]};
      A_AMPL: rd_mux = amp;
      A_RATED: rd_mux = rated;
      A_CLAMP: rd_mux = clamp;
      A_COMP: rd_mux = comp;
      A_NORM: rd_mux = norm;
      A_FBCTL: rd_mux = fbctl;
      A_TIMING: rd_mux = timing;
      A_LOOP3: rd_mux = loop3;
      A_OLPER: rd_mux = olper;
      A_PERIOD: rd_mux = eng.period;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Two-wire register port
  // ----------------------------------------------------------------
  hcl_i2c_t ist;
  logic [3:0] bitcnt;
  logic [7:0] shreg, ptr;
  logic rw, nack;

  wire scl_rise = scl_s2 && !scl_s3;
  wire scl_fall = !scl_s2 && scl_s3;
  wire bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  wire bus_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  wire rx_state = ist == I_ADDR || ist == I_PTR || ist == I_WDAT;
  wire byte_in = bitcnt == 4'h8;
  wire wr_en = scl_fall && ist == I_WDAT && byte_in;
  wire [7:0] ptr_inc = ptr + 8'h01;
  wire next_drive_low = ist == I_ACKA || ist == I_ACKP || ist == I_ACKW ||
                        (ist == I_RDAT && !shreg[7]);

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ist <= I_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
    end else if (bus_start) begin
      ist <= I_ADDR;
      bitcnt <= 4'h0;
    end else if (bus_stop) begin
      ist <= I_IDLE;
    end else if (scl_rise) begin
      if (rx_state) begin
        shreg <= {shreg[6:0], sda_s2};
        bitcnt <= bitcnt + 4'h1;
      end
      if (ist == I_RACK) begin
        nack <= sda_s2;
      end
    end else if (scl_fall) begin
      unique case (ist)
        I_IDLE: ist <= I_IDLE;
        I_ADDR: if (byte_in) begin
          ist <= shreg[7:1] == DEV_ADDR ? I_ACKA : I_IDLE;
          rw <= shreg[0];
        end
        I_ACKA: begin
          bitcnt <= 4'h0;
          ist <= rw ? I_RDAT : I_PTR;
          shreg <= rd_mux(ptr);
        end
        I_PTR: if (byte_in) begin
          ptr <= shreg;
          ist <= I_ACKP;
        end
        I_ACKP: begin
          bitcnt <= 4'h0;
          ist <= I_WDAT;
        end
        I_WDAT: if (byte_in) begin
          ist <= I_ACKW;
        end
        I_ACKW: begin
          bitcnt <= 4'h0;
          ptr <= ptr_inc;
          ist <= I_WDAT;
        end
        I_RDAT: if (bitcnt == 4'h7) begin
          bitcnt <= 4'h0;
          ist <= I_RACK;
        end else begin
          shreg <= {shreg[6:0], 1'b0};
          bitcnt <= bitcnt + 4'h1;
        end
        I_RACK: if (!nack) begin
          ptr <= ptr_inc;
          shreg <= rd_mux(ptr_inc);
          ist <= I_RDAT;
        end else begin
          ist <= I_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register writes and level calibration
  // ----------------------------------------------------------------
  logic [MSW-1:0] ms_cnt;
  wire ms_pulse = ms_cnt == MSW'(MS_CYC - 1);
  wire cal_start = wr_en && ptr == A_RUN && shreg[RUN_CAL];
  wire [9:0] cal_len = cal_time == 2'd0 ? CAL_MS0 :
                       cal_time == 2'd1 ? CAL_MS1 :
                       cal_time == 2'd2 ? CAL_MS2 : CAL_MS3;
  wire cal_done = cal_busy && ms_pulse && cal_ms == cal_len;
  wire cal_fail = bemf_s2 < CAL_BEMF_MIN || imp_s2 == IMP_OPEN ||
                  imp_s2 == IMP_SHORT;
  wire [14:0] norm_q = {rated, 7'h00} / {7'h00, bemf_s2};
  wire [7:0] norm_new = norm_q[14:8] != 7'h00 ? 8'hff : norm_q[7:0];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ms_cnt <= '0;
      run_ctl <= RUN_RST;
      {amp, rated, clamp} <= {8'h00, RATED_RST, CLAMP_RST};
      {comp, norm} <= {COMP_RST, NORM_RST};
      {fbctl, timing} <= {FBCTL_RST, TIMING_RST};
      {loop3, olper} <= {LOOP3_RST, OLPER_RST};
      fault_flag <= 1'b0;
      cst <= C_IDLE;
      cal_ms <= 10'h000;
    end else begin
      ms_cnt <= ms_pulse ? '0 : ms_cnt + 1'b1;
      if (wr_en) begin
        unique case (ptr)
          A_RUN: run_ctl <= {shreg[7:2], 1'b0, shreg[RUN_GO]};
          A_AMPL: amp <= shreg;
          A_RATED: rated <= shreg;
          A_CLAMP: clamp <= shreg;
          A_COMP: comp <= shreg;
          A_NORM: norm <= shreg;
          A_FBCTL: fbctl <= shreg;
          A_TIMING: timing <= shreg;
          A_LOOP3: loop3 <= shreg;
          A_OLPER: olper <= shreg;
          default: ;
        endcase
      end
      if (cal_start && !cal_busy) begin
        cst <= C_RUN;
        cal_ms <= 10'h000;
        fault_flag <= 1'b0;
      end else if (cal_done) begin
        cst <= C_IDLE;
        comp <= imp_s2;
        norm <= norm_new;
        fault_flag <= cal_fail;
      end else if (cal_busy && ms_pulse) begin
        cal_ms <= cal_ms + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Resonance engine
  // ----------------------------------------------------------------
  wire running = run_ctl[RUN_GO] || cal_busy;
  wire [4:0] zcw5 = {3'h0, zero_cross_window};
  wire [4:0] dflt = drive_time > zcw5 ? drive_time - zcw5 : 5'h01;

  assign eng.lra = actuator_type_sel;
  assign eng.go = running;
  assign eng.zc = zc_s2 ^ zc_s3;
  assign eng.auto_en = auto_fallback_enable;
  assign eng.unsync_limit = unsync_cycle_limit;
  assign eng.dflt_half = {3'h0, dflt};
  assign eng.ol_period = fallback_period;

  hcl_res_engine u_eng (
    .clk(CLOCK),
    .rst_n(RST_N),
    .e(eng.eng)
  );

  // ----------------------------------------------------------------
  // Feedback loop
  // ----------------------------------------------------------------
  logic [4:0] boost_ms;
  logic go_d;
  wire [15:0] tgt_prod = amp * rated;
  wire [7:0] target = cal_busy ? rated : tgt_prod[15:8];
  wire [15:0] fb_prod = bemf_s2 * norm;
  wire [7:0] fb = fb_prod[15] ? 8'hff : fb_prod[14:7];
  wire boosting = run_ctl[RUN_BOOST] && boost_ms < BOOST_MS;
  wire [2:0] lg_eff = {1'b0, loop_gain} + {2'b00, boosting};
  wire signed [13:0] err = $signed({6'h00, target}) -
                           $signed({6'h00, fb});
  wire signed [13:0] corr = (err <<< lg_eff) >>> 2;
  wire signed [13:0] sum = $signed({6'h00, target}) + corr;
  wire [7:0] drive_fb = sat8(sum, clamp);
  wire braking = running && !eng.auto_open && !cal_busy &&
                 amp == 8'h00 && fb > BRAKE_DONE;
  wire [10:0] brk_prod = fb * ({1'b0, stop_gain_ratio} + 4'h1);
  wire stab = run_ctl[RUN_STAB] && fb < BRAKE_NEAR;
  wire [10:0] brk_shift = stab ? brk_prod >> 2 : brk_prod >> 1;
  wire [7:0] brk_lvl = sat8({3'h0, brk_shift}, clamp);
  wire [7:0] lvl_pre = !running ? 8'h00 :
                       eng.auto_open ? target :
                       braking ? brk_lvl :
                       amp == 8'h00 && !cal_busy ? 8'h00 : drive_fb;
  wire [15:0] comp_prod = lvl_pre * comp;
  wire [7:0] next_level = sat8({6'h00, lvl_pre} +
                               {6'h00, comp_prod[15:8]}, clamp);
  wire next_pol = actuator_type_sel ? eng.phase ^ braking : !braking;

  // ----------------------------------------------------------------
  // Three-level output stage
  // ----------------------------------------------------------------
  logic [7:0] level, pwm_cnt;
  logic pol;
  wire pulse_on = pwm_cnt < level;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      boost_ms <= 5'h00;
      go_d <= 1'b0;
      level <= 8'h00;
      pol <= 1'b0;
      pwm_cnt <= 8'h00;
      OUT_POS <= 1'b0;
      OUT_NEG <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      go_d <= running;
      if (running && !go_d) begin
        boost_ms <= 5'h00;
      end else if (ms_pulse && boosting) begin
        boost_ms <= boost_ms + 5'h01;
      end
      level <= next_level;
      pol <= next_pol;
      pwm_cnt <= pwm_cnt + 8'h01;
      OUT_POS <= pulse_on && pol;
      OUT_NEG <= pulse_on && !pol;
      SDA_OUT <= 1'b0;
      SDA_OE_N <= !next_drive_low;
    end
  end

endmodule // hcl_top

`default_nettype wire

// ### hcl_top_properties.sv
// Purpose: Port-level properties of the haptic controller.
// Assumes: One clock domain with synchronous active-low reset.
// Notes: Run counters catch a bridge leg stuck high for a whole frame.
`default_nettype none

module hcl_top_properties (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  // Output stage
  input wire logic OUT_POS,
  input wire logic OUT_NEG
);
  logic [8:0] pos_run;
  logic [8:0] neg_run;

  always_ff @(posedge CLOCK) begin
    pos_run <= (OUT_POS && RST_N) ? pos_run + 9'h001 : 9'h000;
    neg_run <= (OUT_NEG && RST_N) ? neg_run + 9'h001 : 9'h000;
  end

  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  property p_no_overlap;
    !(OUT_POS && OUT_NEG);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both bridge legs high");
  property p_pos_pulsed;
    pos_run < 9'h100;
  endproperty
  a_pos_pulsed: assert property (p_pos_pulsed)
    else $error("positive leg high for a whole frame");
  property p_neg_pulsed;
    neg_run < 9'h100;
  endproperty
  a_neg_pulsed: assert property (p_neg_pulsed)
    else $error("negative leg high for a whole frame");
  property p_quiet_out;
    $rose(RST_N) |-> (!OUT_POS && !OUT_NEG) [*8];
  endproperty
  a_quiet_out: assert property (p_quiet_out)
    else $error("bridge driven just after reset");

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  property p_quiet_bus;
    $rose(RST_N) |-> SDA_OE_N [*8];
  endproperty
  a_quiet_bus: assert property (p_quiet_bus)
    else $error("data line pulled just after reset");
  property p_open_drain;
    !SDA_OUT;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data line driven high");
  property p_oe_scl_low;
    $changed(SDA_OE_N) |-> !SCL && !$past(SCL, 2);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line changed while clock high");
  property p_oe_hold;
    $fell(SDA_OE_N) |-> !SDA_OE_N [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data line pull too short");
endmodule // hcl_top_properties

bind hcl_top hcl_top_properties chk_u (
  .CLOCK(CLOCK),
  .RST_N(RST_N),
  .SCL(SCL),
  .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N),
  .OUT_POS(OUT_POS),
  .OUT_NEG(OUT_NEG)
);

`default_nettype wire
